// *** rtl/adsc_params.svh ***
`ifndef ADSC_PARAMS_SVH
`define ADSC_PARAMS_SVH

// Register indices (printed offsets); byte address is four times the index
`define ADSC_IDX_CTRL0        8'h1F
`define ADSC_IDX_RESULT       8'h1E
`define ADSC_IDX_PINCFG       8'h9F
`define ADSC_IDX_IRQ_STAT     8'hA0
`define ADSC_IDX_IRQ_MASK     8'hA1
`define ADSC_IDX_AUX          8'hA2

// Control register 0 field positions
`define ADSC_CS_HI            7
`define ADSC_CS_LO            6
`define ADSC_CH_HI            5
`define ADSC_CH_LO            3
`define ADSC_GO_BIT           2
`define ADSC_EN_BIT           0

// Reset values
`define ADSC_CTRL0_RST        8'h00
`define ADSC_PINCFG_RST       3'h0
`define ADSC_RESULT_RST       8'h00

// Bit period counts in oscillator periods
`define ADSC_TAD_SEL0         6'd2
`define ADSC_TAD_SEL1         6'd8
`define ADSC_TAD_SEL2         6'd32
// Bit periods per conversion and after an abort
`define ADSC_CONV_TADS        4'd9
`define ADSC_ABORT_TADS       4'd2
// Last valid channel code
`define ADSC_CH_MAX           3'h4
// Compare unit mode that fires the special event trigger
`define ADSC_CMP_TRIG_MODE    4'hB

`endif

// *** rtl/adsc_pkg.sv ***
package adsc_pkg;
    typedef enum logic [1:0] {
        ADSC_CLK_OSC2  = 2'b00,
        ADSC_CLK_OSC8  = 2'b01,
        ADSC_CLK_OSC32 = 2'b10,
        ADSC_CLK_RC    = 2'b11
    } adsc_clk_sel_t;

    typedef enum logic [2:0] {
        ADSC_ST_OFF     = 3'b000,
        ADSC_ST_ACQ     = 3'b001,
        ADSC_ST_DELAY   = 3'b010,
        ADSC_ST_CONVERT = 3'b011,
        ADSC_ST_ABORT   = 3'b100
    } adsc_state_t;

    typedef struct packed {
        adsc_clk_sel_t clk_sel;
        logic [2:0]    channel;
        logic          go;
        logic          rsvd;
        logic          enable;
    } adsc_ctrl0_t;

    typedef struct packed {
        logic       sample;
        logic [2:0] channel;
        logic       vref_ext;
        logic       power;
    } adsc_front_t;
endpackage : adsc_pkg

// *** rtl/adsc_bit_clock.sv ***
`timescale 1ns/1ps
`include "adsc_params.svh"

// Bit period tick generator: oscillator divider or resynchronised RC tick
module adsc_bit_clock
    import adsc_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Control
    input  wire logic          run,
    input  adsc_clk_sel_t      sel,
    input  wire logic          rc_tick_in,
    // Tick
    output logic               tick
);
    logic [5:0] cnt_q;
    logic [5:0] period;
    logic       rc_s1_q;
    logic       rc_s2_q;
    logic       rc_s3_q;

    always_comb begin
        case (sel)
            ADSC_CLK_OSC2:  period = `ADSC_TAD_SEL0;
            ADSC_CLK_OSC8:  period = `ADSC_TAD_SEL1;
            ADSC_CLK_OSC32: period = `ADSC_TAD_SEL2;
            default:        period = `ADSC_TAD_SEL0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_q <= 6'd0;
        end else if (cnt_q == period - 6'd1) begin
            cnt_q <= 6'd0;
        end else begin
            cnt_q <= cnt_q + 6'd1;
        end
    end

    // RC tick is asynchronous: two flops then an edge detect on the second
    always_ff @(posedge clk) begin
        if (rst) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
        end else begin
            rc_s1_q <= rc_tick_in;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
        end
    end

    assign tick = run && ((sel == ADSC_CLK_RC) ? (rc_s2_q && !rc_s3_q)
                                               : (cnt_q == period - 6'd1));
endmodule : adsc_bit_clock

// *** rtl/adsc_top.sv ***
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "adsc_params.svh"

module adsc_top
    import adsc_pkg::*;
#(
    parameter int INSTR_CYCLES = 4
)(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Device and compare unit
    input  wire logic        SLEEP,
    input  wire logic        RC_TICK,
    input  wire logic [3:0]  CMP_MODE,
    input  wire logic        CMP_EVENT,
    // Analog front end
    input  wire logic        CMP_HIGH,
    output adsc_front_t      FRONT,
    output logic [7:0]       DAC_CODE,
    output logic [2:0]       PIN_CFG,
    // Interrupt
    output logic             IRQ
);
    localparam int IW = $clog2(INSTR_CYCLES + 1);

    adsc_ctrl0_t  ctrl_q;
    adsc_state_t  state_q;
    logic [7:0]   result_q;
    logic [2:0]   pincfg_q;
    logic [1:0]   stat_q;
    logic [1:0]   mask_q;
    logic [7:0]   sar_q;
    logic [3:0]   tads_q;
    logic [IW-1:0] wait_q;
    logic         tick;
    logic         wr;
    logic         rd;
    logic [9:0]   idx;
    logic         go_set;
    logic         go_clr;
    logic         done_ev;
    logic         abort_ev;
    logic         sleep_kill;
    logic         mapped;

    function automatic logic [7:0] rd_idx(input logic [9:0] i);
        return i[7:0];
    endfunction : rd_idx

    assign idx  = PADDR[11:2];
    assign wr   = PSEL && PENABLE && PWRITE;
    assign rd   = PSEL && !PENABLE && !PWRITE;
    assign mapped = (idx[9:8] == 2'b00) &&
        (rd_idx(idx) == `ADSC_IDX_CTRL0  || rd_idx(idx) == `ADSC_IDX_RESULT ||
         rd_idx(idx) == `ADSC_IDX_PINCFG || rd_idx(idx) == `ADSC_IDX_IRQ_STAT ||
         rd_idx(idx) == `ADSC_IDX_IRQ_MASK);
    wire ctrl_wr = wr && idx == {2'b00, `ADSC_IDX_CTRL0};
    wire busy    = state_q == ADSC_ST_DELAY || state_q == ADSC_ST_CONVERT;

    // Start by software or by the compare unit, only while enabled
    assign go_set = ctrl_q.enable && state_q == ADSC_ST_ACQ && !sleep_kill &&
        ((ctrl_wr && PWDATA[`ADSC_GO_BIT] && PWDATA[`ADSC_EN_BIT]
          && ctrl_q.enable) ||
         (CMP_EVENT && CMP_MODE == `ADSC_CMP_TRIG_MODE));
    assign go_clr   = ctrl_wr && !PWDATA[`ADSC_GO_BIT];
    assign abort_ev = busy && go_clr;
    assign sleep_kill = SLEEP && ctrl_q.clk_sel != ADSC_CLK_RC;
    assign done_ev  = state_q == ADSC_ST_CONVERT && tick &&
                      tads_q == `ADSC_CONV_TADS - 4'd1 &&
                      !abort_ev && !sleep_kill && ctrl_q.enable;

    adsc_bit_clock u_clk (
        .clk        (CORE_CLK),
        .rst        (RST),
        // Divider restarts on abort so the wait is two whole bit periods with an oscillator clock; the RC tick is not restarted
        .run        ((state_q == ADSC_ST_CONVERT && !abort_ev) ||
                     state_q == ADSC_ST_ABORT),
        .sel        (ctrl_q.clk_sel),
        .rc_tick_in (RC_TICK),
        .tick       (tick)
    );

    // Control register
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_q <= `ADSC_CTRL0_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_q.clk_sel <= adsc_clk_sel_t'(
                    PWDATA[`ADSC_CS_HI:`ADSC_CS_LO]);
                ctrl_q.channel <= PWDATA[`ADSC_CH_HI:`ADSC_CH_LO];
                ctrl_q.enable  <= PWDATA[`ADSC_EN_BIT];
            end
            // Set wins over clear; done and aborts clear
            if (go_set)
                ctrl_q.go <= 1'b1;
            else if (done_ev || sleep_kill || !ctrl_q.enable ||
                     (ctrl_wr && !PWDATA[`ADSC_EN_BIT]))
                ctrl_q.go <= 1'b0;
            else if (go_clr)
                ctrl_q.go <= 1'b0;
            ctrl_q.rsvd <= 1'b0;
        end
    end

    // Sequencer
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_q <= ADSC_ST_OFF;
            tads_q  <= 4'd0;
            wait_q  <= '0;
            sar_q   <= 8'h00;
        end else if (!ctrl_q.enable || sleep_kill) begin
            state_q <= ADSC_ST_OFF;
        end else begin
            case (state_q)
                ADSC_ST_OFF: state_q <= ADSC_ST_ACQ;
                ADSC_ST_ACQ: if (go_set) begin
                    sar_q  <= 8'h80;
                    tads_q <= 4'd0;
                    wait_q <= '0;
                    state_q <= (ctrl_q.clk_sel == ADSC_CLK_RC) ?
                               ADSC_ST_DELAY : ADSC_ST_CONVERT;
                end
                ADSC_ST_DELAY: begin
                    wait_q <= wait_q + 1'b1;
                    if (abort_ev) begin
                        state_q <= ADSC_ST_ABORT;
                        tads_q  <= 4'd0;
                    end else if (wait_q == IW'(INSTR_CYCLES - 1))
                        state_q <= ADSC_ST_CONVERT;
                end
                ADSC_ST_CONVERT: begin
                    if (abort_ev) begin
                        state_q <= ADSC_ST_ABORT;
                        tads_q  <= 4'd0;
                    end else if (tick) begin
                        tads_q <= tads_q + 4'd1;
                        if (tads_q >= 4'd1 && tads_q <= 4'd8) begin
                            // One bit decided per bit period
                            sar_q <= trial(sar_q, tads_q, CMP_HIGH);
                        end
                        if (done_ev)
                            state_q <= ADSC_ST_ACQ;
                    end
                end
                ADSC_ST_ABORT: if (tick) begin
                    tads_q <= tads_q + 4'd1;
                    if (tads_q == `ADSC_ABORT_TADS - 4'd1)
                        state_q <= ADSC_ST_ACQ;
                end
                default: state_q <= ADSC_ST_OFF;
            endcase
        end
    end

    // Successive approximation step: bit under test is 8-n
    function automatic logic [7:0] trial(input logic [7:0] s,
                                         input logic [3:0] n,
                                         input logic       high);
        logic [7:0] r;
        logic [2:0] b;
        r = s;
        b = 3'(4'd8 - n);
        if (high)
            r[b] = 1'b0;
        if (b != 3'd0)
            r[b - 3'd1] = 1'b1;
        return r;
    endfunction : trial

    // Result, pin config, interrupt status and mask
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            result_q <= `ADSC_RESULT_RST;
            pincfg_q <= `ADSC_PINCFG_RST;
            stat_q   <= 2'b00;
            mask_q   <= 2'b00;
        end else begin
            if (done_ev)
                result_q <= trial(sar_q, 4'd8, CMP_HIGH);
            else if (wr && idx == {2'b00, `ADSC_IDX_RESULT})
                result_q <= PWDATA[7:0];
            if (wr && idx == {2'b00, `ADSC_IDX_PINCFG})
                pincfg_q <= PWDATA[2:0];
            if (wr && idx == {2'b00, `ADSC_IDX_IRQ_MASK})
                mask_q <= PWDATA[1:0];
            stat_q[0] <= done_ev ||
                (stat_q[0] && !(wr && idx == {2'b00, `ADSC_IDX_IRQ_STAT}
                 && PWDATA[0]));
            stat_q[1] <= abort_ev ||
                (stat_q[1] && !(wr && idx == {2'b00, `ADSC_IDX_IRQ_STAT}
                 && PWDATA[1]));
        end
    end

    // Front end drive and APB answer
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            FRONT    <= '0;
            DAC_CODE <= 8'h00;
            PIN_CFG  <= `ADSC_PINCFG_RST;
            IRQ      <= 1'b0;
            PRDATA   <= 32'h0000_0000;
            PREADY   <= 1'b0;
            PSLVERR  <= 1'b0;
        end else begin
            FRONT.power    <= ctrl_q.enable && !sleep_kill;
            FRONT.channel  <= (ctrl_q.channel > `ADSC_CH_MAX) ?
                              3'h0 : ctrl_q.channel;
            FRONT.sample   <= state_q == ADSC_ST_ACQ;
            FRONT.vref_ext <= pincfg_q[0];
            DAC_CODE       <= sar_q;
            PIN_CFG        <= pincfg_q;
            IRQ            <= |(stat_q & mask_q);
            PREADY         <= PSEL && !PENABLE;
            PSLVERR        <= PSEL && !PENABLE && !mapped;
            if (rd) begin
                case (idx)
                    {2'b00, `ADSC_IDX_CTRL0}:
                        PRDATA <= {24'h0, ctrl_q};
                    {2'b00, `ADSC_IDX_RESULT}:
                        PRDATA <= {24'h0, result_q};
                    {2'b00, `ADSC_IDX_PINCFG}:
                        PRDATA <= {29'h0, pincfg_q};
                    {2'b00, `ADSC_IDX_IRQ_STAT}:
                        PRDATA <= {30'h0, stat_q};
                    {2'b00, `ADSC_IDX_IRQ_MASK}:
                        PRDATA <= {30'h0, mask_q};
                    default: PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks
    logic [3:0] conv_ticks;
    always_ff @(posedge CORE_CLK) begin
        if (RST || state_q != ADSC_ST_CONVERT)
            conv_ticks <= 4'd0;
        else if (tick)
            conv_ticks <= conv_ticks + 4'd1;
    end

    go_clears_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        done_ev |=> !ctrl_q.go)
        else $error("status bit not cleared after result");
    nine_tads_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        done_ev |-> conv_ticks == 4'd8)
        else $error("conversion length not nine bit periods");
    abort_keeps_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        abort_ev |=> $stable(result_q) && state_q == ADSC_ST_ABORT)
        else $error("abort changed result");
    off_when_dis_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !ctrl_q.enable |=> !FRONT.power)
        else $error("front end powered while disabled");
    sleep_kill_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        sleep_kill && ctrl_q.enable |=> state_q == ADSC_ST_OFF
        && ctrl_q.enable)
        else $error("sleep did not abort non-RC conversion");
    rc_delay_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        state_q == ADSC_ST_ACQ && go_set && ctrl_q.clk_sel == ADSC_CLK_RC
        |=> state_q == ADSC_ST_DELAY)
        else $error("RC start skipped the delay");
    trig_dis_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !ctrl_q.enable |-> !go_set)
        else $error("trigger started while disabled");
    chan_range_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        ##1 FRONT.channel <= `ADSC_CH_MAX)
        else $error("channel out of range");
    reset_off_a: assert property (
        @(posedge CORE_CLK)
        RST |=> state_q == ADSC_ST_OFF && ctrl_q == 8'h00)
        else $error("reset did not power down");
    done_status_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        done_ev |=> stat_q[0])
        else $error("done event did not set status");
    result_load_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        done_ev |=> result_q == sar_q)
        else $error("result differs from final trial code");
    abort_len_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        state_q == ADSC_ST_ABORT |-> tads_q <= 4'd1)
        else $error("abort wait longer than two bit periods");
    rc_sleep_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        state_q == ADSC_ST_CONVERT && SLEEP && ctrl_q.clk_sel == ADSC_CLK_RC
        && ctrl_q.enable && !abort_ev && !done_ev
        |=> state_q == ADSC_ST_CONVERT)
        else $error("sleep stopped an RC conversion");
    trig_start_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        CMP_EVENT && CMP_MODE == `ADSC_CMP_TRIG_MODE && ctrl_q.enable
        && state_q == ADSC_ST_ACQ && !sleep_kill |=> ctrl_q.go)
        else $error("trigger did not start a conversion");
    ready_one_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        PREADY |=> !PREADY)
        else $error("ready stood for more than one cycle");

    // Main scenarios
    conv_done_c: cover property (@(posedge CORE_CLK) disable iff (RST)
        done_ev);
    abort_c: cover property (@(posedge CORE_CLK) disable iff (RST)
        abort_ev);
    trig_c: cover property (@(posedge CORE_CLK) disable iff (RST)
        CMP_EVENT && go_set);
    rc_sleep_c: cover property (@(posedge CORE_CLK) disable iff (RST)
        state_q == ADSC_ST_CONVERT && SLEEP);
    sleep_kill_c: cover property (@(posedge CORE_CLK) disable iff (RST)
        sleep_kill && busy);
endmodule : adsc_top

// *** tb/adsc_front_model.sv ***
`timescale 1ns/1ps

// Front end: hold capacitor tracks while sampling, comparator against DAC
module adsc_front_model
    import adsc_pkg::*;
(
    // Clock
    input  wire logic            clk,
    // Converter side
    input  adsc_front_t          front,
    input  wire logic [7:0]      dac,
    input  wire logic [4:0][7:0] vin,
    output logic                 cmp_high
);
    logic [7:0] held_q = 8'h00;
    logic       toggle_q = 1'b0;

    always @(posedge clk) begin
        toggle_q <= ~toggle_q;
        if (front.power && front.sample && front.channel <= 3'h4) begin
            held_q <= vin[front.channel];
        end
    end

    // Unpowered comparator output is meaningless, so keep it moving
    always_comb begin
        if (front.power) begin
            cmp_high = held_q < dac;
        end else begin
            cmp_high = toggle_q;
        end
    end
endmodule : adsc_front_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "adsc_params.svh"

module tb
    import adsc_pkg::*;
;
    localparam logic [11:0] A_CTL = {2'h0, `ADSC_IDX_CTRL0, 2'h0};
    localparam logic [11:0] A_RES = {2'h0, `ADSC_IDX_RESULT, 2'h0};
    localparam logic [11:0] A_PIN = {2'h0, `ADSC_IDX_PINCFG, 2'h0};
    localparam logic [11:0] A_STA = {2'h0, `ADSC_IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] A_MSK = {2'h0, `ADSC_IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] A_BAD = 12'h040;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;

    logic            clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata;
    logic            sleep, cmp_event, cmp_high, irq;
    logic            rc_tick = 1'b0;
    logic [3:0]      cmp_mode;
    logic [1:0]      rc_cnt = 2'h0;
    adsc_front_t     front;
    logic [7:0]      dac, last;
    logic [2:0]      pin_cfg;
    logic [4:0][7:0] vin;
    logic [65:0]     expq[$];
    logic [65:0]     e;
    int              n_fail, num_checks, seed;
    int              tadv[3] = '{2, 8, 32};

    adsc_top #(.INSTR_CYCLES(4)) uut (
        .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SLEEP(sleep),
        .RC_TICK(rc_tick), .CMP_MODE(cmp_mode), .CMP_EVENT(cmp_event),
        .CMP_HIGH(cmp_high), .FRONT(front), .DAC_CODE(dac),
        .PIN_CFG(pin_cfg), .IRQ(irq)
    );

    adsc_front_model afe (
        .clk(clk), .front(front), .dac(dac), .vin(vin),
        .cmp_high(cmp_high)
    );

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] s, x);
        num_checks++;
        if (s !== x) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, x, s);
        end
    endtask : chk

    function automatic logic [31:0] ctl(input logic [1:0] cs,
                                        input logic [2:0] ch,
                                        input logic go, en);
        return {24'h0, cs, ch, go, 1'b0, en};
    endfunction : ctl

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, x, m, input logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        expq.push_back({wr, err, m, x});
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_irq(input int lo, hi);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < hi) begin
            @(posedge clk);
            n++;
        end
        chk("irq_delay", 32'(n >= lo && n < hi), 32'h1);
    endtask : wait_irq

    task automatic convert(input logic [1:0] cs, input logic [2:0] ch,
                           input int lo, hi);
        apb(1'b1, A_CTL, ctl(cs, ch, 1'b0, 1'b1), 0, 0, 1'b0);
        repeat (20) @(posedge clk); // Settling time
        chk("front_ch", {29'h0, front.channel}, {29'h0, ch});
        chk("sample", {31'h0, front.sample}, 32'h1);
        apb(1'b1, A_CTL, ctl(cs, ch, 1'b1, 1'b1), 0, 0, 1'b0);
        wait_irq(lo, hi);
        chk("dac", {24'h0, dac}, {24'h0, vin[ch]});
        apb(1'b0, A_CTL, 0, ctl(cs, ch, 1'b0, 1'b1), ALL, 1'b0);
        apb(1'b0, A_RES, 0, {24'h0, vin[ch]}, ALL, 1'b0);
        apb(1'b1, A_STA, 32'h1, 0, 0, 1'b0);
        last = vin[ch];
    endtask : convert

    task automatic pulse_event(input logic [3:0] mode);
        cmp_mode <= mode;
        @(posedge clk);
        cmp_event <= 1'b1;
        @(posedge clk);
        cmp_event <= 1'b0;
    endtask : pulse_event

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, e[64]});
            if (!e[65]) begin
                chk("prdata", prdata & e[63:32], e[31:0] & e[63:32]);
            end
        end
    end

    always @(posedge clk) begin
        rc_cnt <= rc_cnt + 2'h1;
        if (rc_cnt == 2'h3) begin
            rc_tick <= ~rc_tick;
        end
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; sleep = 1'b0;
        cmp_mode = 4'h0; cmp_event = 1'b0; last = 8'h00;
        seed = 32'h039c;
        for (int i = 0; i < 5; i++) vin[i] = 8'($random(seed));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk("power", {31'h0, front.power}, 32'h0);
        apb(1'b0, A_CTL, 0, 0, ALL, 1'b0);
        apb(1'b0, A_RES, 0, 0, ALL, 1'b0);
        apb(1'b0, A_PIN, 0, 0, ALL, 1'b0);
        apb(1'b0, A_BAD, 0, 0, ALL, 1'b1);
        apb(1'b1, A_BAD, 32'h5, 0, 0, 1'b1);
        apb(1'b1, A_MSK, 32'h3, 0, 0, 1'b0);
        apb(1'b1, A_PIN, 32'h5, 0, 0, 1'b0);
        apb(1'b0, A_PIN, 0, 32'h5, 32'h7, 1'b0);
        chk("pin_cfg", {29'h0, pin_cfg}, 32'h5);
        chk("vref", {31'h0, front.vref_ext}, 32'h1);
        apb(1'b1, A_PIN, 32'h0, 0, 0, 1'b0);
        // Shortest legal bit period depends on the oscillator
        for (int c = 0; c < 3; c++) begin
            for (int h = 0; h < 5; h++) begin
                convert(2'(c), 3'(h), 9 * tadv[c], 10 * tadv[c] + 12);
            end
        end
        sleep <= 1'b1;
        convert(2'h3, 3'h2, 68, 120);
        sleep <= 1'b0;
        apb(1'b1, A_CTL, ctl(2'h2, 3'h1, 1'b0, 1'b1), 0, 0, 1'b0);
        apb(1'b1, A_CTL, ctl(2'h2, 3'h1, 1'b1, 1'b1), 0, 0, 1'b0);
        repeat (40) @(posedge clk);
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        chk("power", {31'h0, front.power}, 32'h0);
        apb(1'b0, A_CTL, 0, 32'h1, 32'h1, 1'b0);
        repeat (400) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        sleep <= 1'b0;
        apb(1'b1, A_CTL, ctl(2'h2, 3'h0, 1'b0, 1'b1), 0, 0, 1'b0);
        apb(1'b1, A_STA, 32'h3, 0, 0, 1'b0);
        repeat (20) @(posedge clk);
        apb(1'b1, A_CTL, ctl(2'h2, 3'h0, 1'b1, 1'b1), 0, 0, 1'b0);
        repeat (100) @(posedge clk);
        apb(1'b1, A_CTL, ctl(2'h2, 3'h0, 1'b0, 1'b1), 0, 0, 1'b0);
        repeat (5) @(posedge clk);
        apb(1'b0, A_STA, 0, 32'h2, 32'h3, 1'b0);
        apb(1'b0, A_RES, 0, {24'h0, last}, ALL, 1'b0);
        apb(1'b1, A_STA, 32'h2, 0, 0, 1'b0);
        repeat (70) @(posedge clk);
        convert(2'h2, 3'h0, 288, 340);
        pulse_event(4'hB);
        wait_irq(288, 340);
        apb(1'b0, A_RES, 0, {24'h0, vin[0]}, ALL, 1'b0);
        apb(1'b1, A_STA, 32'h1, 0, 0, 1'b0);
        pulse_event(4'hA);
        repeat (400) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, A_CTL, ctl(2'h0, 3'h0, 1'b0, 1'b0), 0, 0, 1'b0);
        repeat (3) @(posedge clk);
        chk("power", {31'h0, front.power}, 32'h0);
        pulse_event(4'hB);
        apb(1'b1, A_CTL, ctl(2'h0, 3'h0, 1'b1, 1'b1), 0, 0, 1'b0);
        repeat (60) @(posedge clk);
        apb(1'b0, A_STA, 0, 32'h0, 32'h3, 1'b0);
        apb(1'b1, A_MSK, 32'h0, 0, 0, 1'b0);
        apb(1'b1, A_CTL, ctl(2'h0, 3'h1, 1'b0, 1'b1), 0, 0, 1'b0);
        repeat (20) @(posedge clk);
        apb(1'b1, A_CTL, ctl(2'h0, 3'h1, 1'b1, 1'b1), 0, 0, 1'b0);
        repeat (40) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b0, A_STA, 0, 32'h1, 32'h3, 1'b0);
        apb(1'b1, A_MSK, 32'h1, 0, 0, 1'b0);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, A_STA, 32'h1, 0, 0, 1'b0);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, A_CTL, ctl(2'h2, 3'h3, 1'b1, 1'b1), 0, 0, 1'b0);
        repeat (50) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("power", {31'h0, front.power}, 32'h0);
        apb(1'b0, A_CTL, 0, 0, ALL, 1'b0);
        apb(1'b0, A_RES, 0, 0, ALL, 1'b0);
        report_and_stop();
    end
endmodule : tb
